// ===== core/sats_cfg.svh
// Purpose: Constants of the conversion trigger sequencer
// Assumes: Included by the package and by the top module; the edge detector does not include it
// Notes:   Byte addresses on the register bus, counts in conversion clocks
`ifndef SATS_CFG_SVH
`define SATS_CFG_SVH

`define SATS_NTRIG      32
`define SATS_NSLOT      24
`define SATS_RES_W      12
`define SATS_SLOT_LAST  5'd23

// Conversion timing, in conversion-clock cycles
`define SATS_CONV_STD   5'd16
`define SATS_CONV_ENH   5'd20
`define SATS_SH_CYC     5'd3
`define SATS_BIT_LAST   5'd14
`define SATS_MSB        4'd11
`define SATS_ADCLK_DIV  4'd1

// Register map
`define SATS_A_CTRL     8'h00
`define SATS_A_STATUS   8'h04
`define SATS_A_EDGE_LO  8'h08
`define SATS_A_EDGE_HI  8'h0C
`define SATS_A_FORCE    8'h10
`define SATS_A_MAN_RES  8'h14
`define SATS_A_PMX      8'h18
`define SATS_A_PEND     8'h1C
`define SATS_PG_MISC    4'h0
`define SATS_PG_TRIG    4'h1
`define SATS_PG_SLOT    4'h2
`define SATS_PG_RES     4'h3

// Field positions
`define SATS_CTRL_W     14
`define SATS_CTRL_START 6
`define SATS_TRIG_W     13
`define SATS_SLOT_W     15
`define SATS_PMX_W      10

`endif

// ===== core/sats_pkg.sv
// Purpose: Types shared by the conversion trigger sequencer
// Assumes: sats_cfg.svh holds the numbers
// Notes:   Field order of each struct matches its register layout
`include "sats_cfg.svh"

package sats_pkg;

   typedef enum logic [1:0] {
      SQ_IDLE  = 2'b00,
      SQ_SETUP = 2'b01,
      SQ_CONV  = 2'b11,
      SQ_STORE = 2'b10
   } sats_seq_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sats_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } sats_apb_rsp_s;

   typedef struct packed {
      logic [7:0] sel;
      logic       hold;
   } sats_pmx_s;

   typedef struct packed {
      logic [3:0]                 chan;
      logic                       sample;
      logic [`SATS_RES_W-1:0]     trial;
      logic                       pwr_dn;
   } sats_sar_s;

   typedef struct packed {
      logic [3:0] man_chan;
      logic [1:0] man_line;
      logic       man_ien;
      logic       rsvd;
      logic       seq_end;
      logic       queue;
      logic       repeat_en;
      logic       enh;
      logic       manual;
      logic       en;
   } sats_ctrl_s;

   typedef struct packed {
      logic [1:0] line;
      logic       ien;
      logic [4:0] cnt;
      logic [4:0] first;
   } sats_trig_s;

   typedef struct packed {
      logic [1:0] line;
      logic       ien;
      logic [7:0] sel;
      logic [3:0] chan;
   } sats_slot_s;

   typedef struct packed {
      logic       ovr;
      logic       hold;
      logic [7:0] sel;
   } sats_pmxreg_s;

endpackage

// ===== core/sats_edge_det.sv
// Purpose: Per-input edge detector with rising/falling selection
// Assumes: Inputs synchronous to core_clk
// Notes:   No event in the first cycle after reset
`timescale 1ns/1ps
`default_nettype none

module sats_edge_det #(
   parameter int W = 32
) (
   input  wire logic           core_clk,
   input  wire logic           sys_rst,
   input  wire logic [W-1:0]   sig_in,
   input  wire logic [2*W-1:0] edge_cfg,
   output logic      [W-1:0]   ev
);

   typedef struct packed {
      logic         primed;
      logic [W-1:0] prev;
   } sats_ed_st_s;

   sats_ed_st_s st_reg;
   sats_ed_st_s st_next;

   always_comb begin
      st_next.primed = 1'b1;
      st_next.prev   = sig_in;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   for (genvar i = 0; i < W; i++) begin : g_ev
      assign ev[i] = st_reg.primed &
                     ((sig_in[i] & ~st_reg.prev[i] & edge_cfg[2*i]) |
                      (~sig_in[i] & st_reg.prev[i] & edge_cfg[2*i+1]));
   end

endmodule

`default_nettype wire

// ===== core/sats_top.sv
// Purpose: 12-bit SAR control with trigger sequencer, result store, premux link
// Assumes: APB slave with one wait state; comparator answers within the
//          cycle in which each trial code is presented
// Notes:   Overview of operation follows
//
// Overview of operation
// - 12-bit successive approximation, fixed clock count
// - Channel selects direct inputs 0-7 or front end
// - Power-down when disabled; manual conversion can interrupt
// - Repeat or single shot, manual and sequences
// - Standard mode conversion takes 16 clocks
// - Enhanced mode conversion takes 20 clocks
// - Sample phase lasts 3 conversion clocks
// - Sequences run with no processor action
// - Each slot result copied to its storage
// - 32 trigger inputs, rising, falling or both
// - Register write forces a trigger like hardware
// - Each trigger chains 1 to 24 conversions
// - Per-slot enable raises interrupt on completion
// - Interrupt goes to one of four lines
// - Interrupt per slot or at sequence end
// - Every slot owns a result register
// - Premux link steered by sequencer or register
`timescale 1ns/1ps
`default_nettype none
`include "sats_cfg.svh"

module sats_top (
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire sats_pkg::sats_apb_req_s apb_req,
   output var  sats_pkg::sats_apb_rsp_s apb_rsp,
   input  wire logic [31:0]             trig_in,
   input  wire logic                    sar_cmp,
   output var  sats_pkg::sats_sar_s     sar_ctl,
   output var  sats_pkg::sats_pmx_s     premux_link,
   output var  logic [3:0]              irq_line
);
   import sats_pkg::*;

   typedef struct packed {
      sats_seq_e                                seq;
      sats_ctrl_s                               ctrl;
      logic [2*`SATS_NTRIG-1:0]                 edge_cfg;
      sats_trig_s [`SATS_NTRIG-1:0]             trig;
      sats_slot_s [`SATS_NSLOT-1:0]             slot;
      logic [`SATS_NSLOT-1:0][`SATS_RES_W-1:0]  res;
      logic [`SATS_RES_W-1:0]                   man_res;
      sats_pmxreg_s                             pmx;
      logic [`SATS_NTRIG-1:0]                   pend;
      logic                                     man_req;
      logic                                     man_act;
      logic [4:0]                               cur_trig;
      logic [4:0]                               idx;
      logic [4:0]                               cnt;
      logic [3:0]                               div;
      sats_apb_rsp_s                            rsp;
      sats_pmx_s                                link;
      sats_sar_s                                sar;
      logic [3:0]                               irq;
   } sats_st_s;

   sats_st_s               st_reg;
   sats_st_s               st_next;
   logic                   wr_fire;
   logic                   acc_wait;
   logic                   hit;
   logic [31:0]            rdata;
   logic [31:0]            edge_ev;
   logic [31:0]            force_ev;
   logic [31:0]            accepted;
   logic [4:0]             pick;
   logic [4:0]             slot_raw;
   logic [4:0]             slot_ix;
   logic [4:0]             nconv;
   logic [4:0]             bit_dist;
   logic [3:0]             bit_ix;
   logic                   last_slot;
   logic                   ce;
   logic [`SATS_RES_W-1:0] trial;
   sats_trig_s             tcfg;
   sats_slot_s             scfg;

   //--------------------------------------------------------------
   // Trigger inputs and selection
   //--------------------------------------------------------------
   sats_edge_det #(
      .W (`SATS_NTRIG)
   ) u_edge (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .sig_in   (trig_in),
      .edge_cfg (st_reg.edge_cfg),
      .ev       (edge_ev)
   );

   assign wr_fire  = apb_req.psel & apb_req.penable & st_reg.rsp.pready & apb_req.pwrite;
   assign acc_wait = apb_req.psel & apb_req.penable & ~st_reg.rsp.pready;
   assign force_ev = (wr_fire && apb_req.paddr[11:8] == `SATS_PG_MISC &&
                      apb_req.paddr[7:0] == `SATS_A_FORCE) ? apb_req.pwdata : '0;

   // Busy-time events are dropped unless queueing is on
   always_comb begin
      accepted = '0;
      if (st_reg.ctrl.en && !st_reg.ctrl.manual) begin
         accepted = edge_ev | force_ev;
         if (st_reg.seq != SQ_IDLE && !st_reg.ctrl.queue) begin
            accepted = '0;
         end
      end
   end

   always_comb begin
      pick = '0;
      for (int i = `SATS_NTRIG - 1; i >= 0; i--) begin
         if (st_reg.pend[i]) begin
            pick = 5'(i);
         end
      end
   end

   assign tcfg      = st_reg.trig[st_reg.cur_trig];
   assign slot_raw  = tcfg.first + st_reg.idx;
   assign slot_ix   = (slot_raw > `SATS_SLOT_LAST) ? `SATS_SLOT_LAST : slot_raw;
   assign scfg      = st_reg.slot[slot_ix];
   assign last_slot = (5'(st_reg.idx + 5'd1) >= tcfg.cnt) ||
                      (slot_ix == `SATS_SLOT_LAST);
   assign ce        = (st_reg.div == 4'(`SATS_ADCLK_DIV - 4'd1));
   assign nconv     = st_reg.ctrl.enh ? `SATS_CONV_ENH : `SATS_CONV_STD;
   assign bit_dist  = `SATS_BIT_LAST - st_reg.cnt;
   assign bit_ix    = bit_dist[3:0];

   //--------------------------------------------------------------
   // Register read decode
   //--------------------------------------------------------------
   always_comb begin
      hit   = 1'b1;
      rdata = '0;
      unique case (apb_req.paddr[11:8])
         `SATS_PG_MISC: begin
            unique case (apb_req.paddr[7:0])
               `SATS_A_CTRL:    rdata = 32'(st_reg.ctrl);
               `SATS_A_STATUS:  rdata = {20'h00000, st_reg.idx, st_reg.cur_trig,
                                         st_reg.man_act, st_reg.seq != SQ_IDLE};
               `SATS_A_EDGE_LO: rdata = st_reg.edge_cfg[31:0];
               `SATS_A_EDGE_HI: rdata = st_reg.edge_cfg[63:32];
               `SATS_A_FORCE:   rdata = '0;
               `SATS_A_MAN_RES: rdata = 32'(st_reg.man_res);
               `SATS_A_PMX:     rdata = 32'(st_reg.pmx);
               `SATS_A_PEND:    rdata = st_reg.pend;
               default:         hit = 1'b0;
            endcase
         end
         `SATS_PG_TRIG: begin
            hit   = ~apb_req.paddr[7];
            rdata = hit ? 32'(st_reg.trig[apb_req.paddr[6:2]]) : '0;
         end
         `SATS_PG_SLOT: begin
            hit   = (apb_req.paddr[7:2] <= 6'(`SATS_SLOT_LAST));
            rdata = hit ? 32'(st_reg.slot[apb_req.paddr[6:2]]) : '0;
         end
         `SATS_PG_RES: begin
            hit   = (apb_req.paddr[7:2] <= 6'(`SATS_SLOT_LAST));
            rdata = hit ? 32'(st_reg.res[apb_req.paddr[6:2]]) : '0;
         end
         default: hit = 1'b0;
      endcase
   end

   //--------------------------------------------------------------
   // Next state
   //--------------------------------------------------------------
   always_comb begin
      st_next     = st_reg;
      st_next.irq = '0;
      trial       = st_reg.sar.trial;

      // Bus slave: one wait state, answer registered
      st_next.rsp = '0;
      if (acc_wait) begin
         st_next.rsp.pready  = 1'b1;
         st_next.rsp.prdata  = rdata;
         st_next.rsp.pslverr = ~hit;
      end

      if (wr_fire && hit) begin
         unique case (apb_req.paddr[11:8])
            `SATS_PG_MISC: begin
               unique case (apb_req.paddr[7:0])
                  `SATS_A_CTRL: begin
                     st_next.ctrl      = apb_req.pwdata[`SATS_CTRL_W-1:0];
                     st_next.ctrl.rsvd = 1'b0;
                     if (apb_req.pwdata[`SATS_CTRL_START]) begin
                        st_next.man_req = 1'b1;
                     end
                  end
                  `SATS_A_EDGE_LO: st_next.edge_cfg[31:0]  = apb_req.pwdata;
                  `SATS_A_EDGE_HI: st_next.edge_cfg[63:32] = apb_req.pwdata;
                  `SATS_A_PMX:     st_next.pmx = apb_req.pwdata[`SATS_PMX_W-1:0];
                  default: ;
               endcase
            end
            `SATS_PG_TRIG: st_next.trig[apb_req.paddr[6:2]] = apb_req.pwdata[`SATS_TRIG_W-1:0];
            `SATS_PG_SLOT: st_next.slot[apb_req.paddr[6:2]] = apb_req.pwdata[`SATS_SLOT_W-1:0];
            default: ;
         endcase
      end

      st_next.div = ce ? 4'h0 : 4'(st_reg.div + 4'd1);

      // Sequencer and conversion engine
      unique case (st_reg.seq)
         SQ_IDLE: begin
            if (st_reg.ctrl.en && st_reg.ctrl.manual && st_reg.man_req) begin
               st_next.man_req  = 1'b0;
               st_next.man_act  = 1'b1;
               st_next.seq      = SQ_SETUP;
            end else if (st_reg.ctrl.en && !st_reg.ctrl.manual && |st_reg.pend) begin
               st_next.pend[pick] = 1'b0;
               st_next.cur_trig   = pick;
               st_next.idx        = '0;
               st_next.seq        = SQ_SETUP;
            end
         end
         SQ_SETUP: begin
            st_next.sar.chan   = st_reg.man_act ? st_reg.ctrl.man_chan : scfg.chan;
            st_next.link.sel   = scfg.sel;
            st_next.link.hold  = 1'b1;
            st_next.sar.trial  = '0;
            st_next.sar.sample = 1'b1;
            st_next.cnt        = '0;
            st_next.seq        = SQ_CONV;
         end
         SQ_CONV: begin
            if (ce) begin
               st_next.cnt = 5'(st_reg.cnt + 5'd1);
               if (st_reg.cnt == `SATS_SH_CYC - 5'd1) begin
                  st_next.sar.sample          = 1'b0;
                  st_next.link.hold           = 1'b0;
                  st_next.sar.trial           = '0;
                  st_next.sar.trial[`SATS_MSB] = 1'b1;
               end
               if (st_reg.cnt >= `SATS_SH_CYC && st_reg.cnt <= `SATS_BIT_LAST) begin
                  if (!sar_cmp) begin
                     trial[bit_ix] = 1'b0;
                  end
                  if (bit_ix != 4'h0) begin
                     trial[bit_ix - 4'd1] = 1'b1;
                  end
                  st_next.sar.trial = trial;
               end
               if (st_reg.cnt == 5'(nconv - 5'd1)) begin
                  st_next.seq = SQ_STORE;
               end
            end
         end
         SQ_STORE: begin
            if (st_reg.man_act) begin
               st_next.man_res = st_reg.sar.trial;
               if (st_reg.ctrl.man_ien) begin
                  st_next.irq[st_reg.ctrl.man_line] = 1'b1;
               end
               if (st_reg.ctrl.repeat_en && st_reg.ctrl.manual) begin
                  st_next.seq = SQ_SETUP;
               end else begin
                  st_next.man_act = 1'b0;
                  st_next.seq     = SQ_IDLE;
               end
            end else begin
               st_next.res[slot_ix] = st_reg.sar.trial;
               if (!st_reg.ctrl.seq_end && scfg.ien) begin
                  st_next.irq[scfg.line] = 1'b1;
               end
               if (last_slot) begin
                  if (st_reg.ctrl.seq_end && tcfg.ien) begin
                     st_next.irq[tcfg.line] = 1'b1;
                  end
                  if (st_reg.ctrl.repeat_en) begin
                     st_next.pend[st_reg.cur_trig] = 1'b1;
                  end
                  st_next.seq = SQ_IDLE;
               end else begin
                  st_next.idx = 5'(st_reg.idx + 5'd1);
                  st_next.seq = SQ_SETUP;
               end
            end
         end
      endcase

      // Disabling powers down and aborts any conversion
      if (!st_reg.ctrl.en) begin
         st_next.seq        = SQ_IDLE;
         st_next.man_act    = 1'b0;
         st_next.pend       = '0;
         st_next.sar.sample = 1'b0;
         st_next.link.hold  = 1'b0;
      end
      st_next.pend       = st_next.pend | accepted;
      st_next.sar.pwr_dn = ~st_next.ctrl.en;

      if (st_reg.pmx.ovr) begin
         st_next.link.sel  = st_reg.pmx.sel;
         st_next.link.hold = st_reg.pmx.hold;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   //--------------------------------------------------------------
   // Outputs
   //--------------------------------------------------------------
   assign apb_rsp     = st_reg.rsp;
   assign sar_ctl     = st_reg.sar;
   assign premux_link = st_reg.link;
   assign irq_line    = st_reg.irq;

endmodule

`default_nettype wire

// ===== verif/sats_properties.sv
// Purpose: Port-level properties of the conversion trigger sequencer
// Assumes: Bound to sats_top; one clock domain
// Notes:   Conversion mode is learned from CTRL writes seen on the bus
`timescale 1ns/1ps
`default_nettype none

module sats_top_checker (
   input wire logic                    core_clk,
   input wire logic                    sys_rst,
   input wire sats_pkg::sats_apb_req_s apb_req,
   input wire sats_pkg::sats_apb_rsp_s apb_rsp,
   input wire logic [31:0]             trig_in,
   input wire logic                    sar_cmp,
   input wire sats_pkg::sats_sar_s     sar_ctl,
   input wire sats_pkg::sats_pmx_s     premux_link,
   input wire logic [3:0]              irq_line
);
   import sats_pkg::*;

   logic       enh_reg;
   logic [7:0] gap_reg;
   logic       unmapped;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   assign unmapped = (apb_req.paddr[11:8] == 4'h0) ? (apb_req.paddr[7:5] != 3'h0 ||
                                                      apb_req.paddr[1:0] != 2'h0) :
                     (apb_req.paddr[11:8] == 4'h1) ? apb_req.paddr[7] :
                     (apb_req.paddr[11:8] <= 4'h3) ? (apb_req.paddr[7:2] > 6'd23) : 1'b1;

   // Cycles since the last start of a sample phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enh_reg <= 1'b0;
         gap_reg <= 8'hFF;
      end else begin
         if (apb_rsp.pready && apb_req.psel && apb_req.pwrite && apb_req.paddr[11:2] == 10'h0) begin
            enh_reg <= apb_req.pwdata[2];
         end
         if ($rose(sar_ctl.sample)) begin
            gap_reg <= 8'h01;
         end else if (gap_reg != 8'hFF) begin
            gap_reg <= gap_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel) && $past(apb_req.penable))
      else $error("pready without access phase");
   a_ready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
      |=> apb_rsp.pready) else $error("pready not one cycle after access");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   a_err_decode: assert property (apb_rsp.pready |-> apb_rsp.pslverr == unmapped)
      else $error("pslverr does not match address decode");
   a_sample_len: assert property ($rose(sar_ctl.sample) |-> sar_ctl.sample[*3] ##1 !sar_ctl.sample)
      else $error("sample phase not three cycles");
   a_trial_first: assert property ($fell(sar_ctl.sample) |-> sar_ctl.trial == 12'h800)
      else $error("first trial code wrong");
   a_conv_len: assert property ($rose(sar_ctl.sample) |-> gap_reg >= (enh_reg ? 8'd22 : 8'd18))
      else $error("conversions closer than their clock count");
   a_irq_single: assert property ($onehot0(irq_line))
      else $error("more than one interrupt line");
   a_irq_pulse: assert property (irq_line != 4'h0 |=> irq_line == 4'h0)
      else $error("interrupt pulse longer than one cycle");
   a_pwrdn_quiet: assert property (sar_ctl.pwr_dn |-> !sar_ctl.sample)
      else $error("sampling while powered down");
endmodule

`default_nettype wire

// ===== verif/sats_sar_model.sv
// Purpose: Comparator and analog levels behind the converter
// Assumes: Comparator answers in the same cycle as its trial code
// Notes:   Front-end channels alias onto the eight direct levels
`timescale 1ns/1ps
`default_nettype none

module sats_sar_model (
   input  wire sats_pkg::sats_sar_s sar_ctl,
   input  wire logic [95:0]         levels,
   output logic                     sar_cmp
);
   import sats_pkg::*;

   assign sar_cmp = (sar_ctl.trial <= levels[sar_ctl.chan[2:0]*12 +: 12]);
endmodule

`default_nettype wire

// ===== verif/sats_top_tb_top.sv
// Purpose: Self-checking bench for the conversion trigger sequencer
// Assumes: APB master with one wait state; comparator model on the far side
// Notes:   Drivers queue expected reads and interrupts, a monitor compares
`timescale 1ns/1ps
`default_nettype none

module sats_top_tb_top;
   import sats_pkg::*;

   logic          core_clk;
   logic          sys_rst;
   sats_apb_req_s apb_req;
   sats_apb_rsp_s apb_rsp;
   logic [31:0]   trig_in;
   logic          sar_cmp;
   sats_sar_s     sar_ctl;
   sats_pmx_s     premux_link;
   logic [3:0]    irq_line;
   logic [95:0]   levels;
   logic [65:0]   rd_q[$];
   logic [3:0]    irq_q[$];
   logic [65:0]   exp_rd;
   logic [3:0]    exp_irq;
   logic [31:0]   rd;
   logic          manual;
   logic [11:0]   zero_regs[9] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014,
                                   12'h01C, 12'h100, 12'h200, 12'h300};
   logic [11:0]   bad_regs[4] = '{12'h020, 12'h260, 12'h360, 12'h400};
   int            bad_count;
   int            compares;
   int            seed;
   int            i;

   sats_top u_sats_top (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .apb_req     (apb_req),
      .apb_rsp     (apb_rsp),
      .trig_in     (trig_in),
      .sar_cmp     (sar_cmp),
      .sar_ctl     (sar_ctl),
      .premux_link (premux_link),
      .irq_line    (irq_line)
   );

   sats_sar_model u_sats_sar_model (
      .sar_ctl  (sar_ctl),
      .levels   (levels),
      .sar_cmp  (sar_cmp)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [11:0] lvl(input int c);
      return levels[c*12 +: 12];
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] m, input logic [32:0] e);
      int n;
      rd_q.push_back({m, e});
      apb_req.psel   <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr  <= a;
      apb_req.pwdata <= d;
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n == 20) begin
         bad_count++;
         wrap_up();
      end
      rd = apb_rsp.prdata;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
      apb(1'b1, a, d, {1'b1, 32'h0}, {err, 32'h0});
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
      apb(1'b0, a, 32'h0, {33{1'b1}}, {err, e});
   endtask

   // Programs a trigger and queues the interrupts its chain should raise
   task automatic run_cfg(input int k, input int first, input int cnt, input logic tien,
                          input logic [1:0] tl, input logic ex);
      int s;
      wr(12'h100 + 12'(4 * k), {19'h0, tl, tien, 5'(cnt), 5'(first)});
      if (ex && tien) irq_q.push_back(4'h1 << tl);
      for (s = first; ex && !tien && s < first + ((cnt == 0) ? 1 : cnt) && s < 24; s++) begin
         irq_q.push_back(4'h1 << (s % 4));
      end
   endtask

   task automatic wait_done();
      int k;
      for (k = 0; k < 3000 && irq_q.size() > 0; k++) @(posedge core_clk);
      do begin
         apb(1'b0, 12'h004, 32'h0, 33'h0, 33'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 3000);
      if (k >= 3000) begin
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic chk_res(input int first, input int n);
      int s;
      for (s = first; s < first + n; s++) rdc(12'h300 + 12'(4 * s), {20'h0, lvl(s % 8)});
   endtask

   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (apb_rsp.pready === 1'b1) begin
         exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : {66{1'b1}};
         check({apb_rsp.pslverr, apb_rsp.prdata} & exp_rd[65:33], exp_rd[32:0]);
      end
      if (sys_rst === 1'b0 && irq_line !== 4'h0) begin
         exp_irq = (irq_q.size() > 0) ? irq_q.pop_front() : 4'h0;
         check({29'h0, irq_line}, {29'h0, exp_irq});
      end
      if (sar_ctl.sample === 1'b1 && !manual) begin
         check({29'h0, premux_link.sel[2:0], premux_link.hold},
               {29'h0, sar_ctl.chan[2:0], 1'b1});
      end
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      bad_count++;
      wrap_up();
   end

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      seed = 35;
      sys_rst = 1'b1;
      apb_req = '0;
      trig_in = 32'h0;
      manual = 1'b0;
      bad_count = 0;
      compares = 0;
      for (i = 0; i < 8; i++) levels[i*12 +: 12] = 12'($random(seed));
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({32'h0, sar_ctl.pwr_dn}, 33'h1);
      foreach (zero_regs[j]) rdc(zero_regs[j], 32'h0);
      foreach (bad_regs[j]) rdc(bad_regs[j], 32'h0, 1'b1);
      wr(12'h400, 32'hFFFF_FFFF, 1'b1);
      for (i = 0; i < 24; i++) wr(12'h200 + 12'(4 * i), {17'h0, 2'(i % 4), 1'b1, 8'(i), 4'(i % 8)});
      rdc(12'h25C, {17'h0, 2'd3, 1'b1, 8'd23, 4'd7});
      wr(12'h008, 32'h0000_0039);
      wr(12'h000, 32'h0000_0001);
      run_cfg(0, 0, 3, 1'b0, 2'd0, 1'b1);
      trig_in <= 32'h0000_0003;
      wait_done();
      chk_res(0, 3);
      run_cfg(1, 22, 5, 1'b0, 2'd0, 1'b1);
      trig_in <= 32'h0000_0001;
      wait_done();
      chk_res(22, 2);
      for (i = 0; i < 2; i++) begin
         run_cfg(2, 5 + i, 1, 1'b0, 2'd0, 1'b1);
         trig_in <= (i == 0) ? 32'h0000_0005 : 32'h0000_0001;
         wait_done();
      end
      chk_res(5, 2);
      run_cfg(3, 10, 0, 1'b0, 2'd0, 1'b1);
      wr(12'h010, 32'h0000_0008);
      wait_done();
      chk_res(10, 1);
      // Busy-time trigger dropped first, then queued
      for (i = 0; i < 2; i++) begin
         if (i == 1) wr(12'h000, 32'h0000_0011);
         run_cfg(5, 11, 5, 1'b0, 2'd0, 1'b1);
         run_cfg(6, 16, 1, 1'b0, 2'd0, i == 1);
         wr(12'h010, 32'h0000_0020);
         wr(12'h010, 32'h0000_0040);
         wait_done();
      end
      chk_res(11, 6);
      wr(12'h000, 32'h0000_0025);
      run_cfg(4, 12, 3, 1'b1, 2'd2, 1'b1);
      wr(12'h010, 32'h0000_0010);
      wait_done();
      chk_res(12, 3);
      manual = 1'b1;
      wr(12'h000, 32'h0000_0B83);
      irq_q.push_back(4'h8);
      wr(12'h000, 32'h0000_0BC3);
      wait_done();
      rdc(12'h014, {20'h0, lvl(2)});
      rdc(12'h000, 32'h0000_0B83);
      irq_q = '{4'h8, 4'h8, 4'h8};
      wr(12'h000, 32'h0000_0BCB);
      for (i = 0; i < 3000 && irq_q.size() > 1; i++) @(posedge core_clk);
      wr(12'h000, 32'h0000_0B83);
      wait_done();
      rdc(12'h014, {20'h0, lvl(2)});
      wr(12'h018, 32'h0000_03A5);
      @(posedge core_clk);
      check({24'h0, premux_link}, {24'h0, 8'hA5, 1'b1});
      wr(12'h018, 32'h0);
      wr(12'h000, 32'h0);
      repeat (2) @(posedge core_clk);
      check({32'h0, sar_ctl.pwr_dn}, 33'h1);
      check(33'(irq_q.size() + rd_q.size()), 33'h0);
      wrap_up();
   end
endmodule

bind sats_top sats_top_checker u_sats_top_checker (
   .core_clk    (core_clk),
   .sys_rst     (sys_rst),
   .apb_req     (apb_req),
   .apb_rsp     (apb_rsp),
   .trig_in     (trig_in),
   .sar_cmp     (sar_cmp),
   .sar_ctl     (sar_ctl),
   .premux_link (premux_link),
   .irq_line    (irq_line)
);

`default_nettype wire
